// file: include/pdm_map.svh
`ifndef PDM_MAP_SVH
`define PDM_MAP_SVH

// ----------------------------------------
// Pin numbering on the flat pin vectors
// ----------------------------------------
`define PDM_NPIN 35
`define PDM_PA_LSB 0
`define PDM_PB_LSB 8
`define PDM_PC_LSB 16
`define PDM_PD_LSB 24
`define PDM_PE_LSB 32
`define PDM_NFUNC 17

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PDM_OFS_DATA_A 5'h00
`define PDM_OFS_DATA_E 5'h04
`define PDM_OFS_DIR_A 5'h05
`define PDM_OFS_DIR_E 5'h09
`define PDM_OFS_LVL_AB 5'h0a
`define PDM_OFS_LVL_CD 5'h0b
`define PDM_OFS_LVL_E 5'h0c
`define PDM_OFS_FN_A_LO 5'h0d
`define PDM_OFS_FN_A_HI 5'h0e
`define PDM_OFS_FN_B_LO 5'h0f

// ----------------------------------------
// Reset values and field layout
// ----------------------------------------
`define PDM_RST_DATA 8'hff
`define PDM_RST_DIR 8'hff
`define PDM_RST_LVL 8'h00
`define PDM_RST_FN 8'h00
`define PDM_LVL_E_MASK 8'h03
`define PDM_PE_MASK 8'h07

`endif

// file: include/pdm_pkg.sv
package pdm_pkg;
	// ----------------------------------------
	// Function carried by a pin; value indexes the peripheral vectors
	// ----------------------------------------
	typedef enum logic [4:0] {
		PDM_FN_GPIO = 5'h00,
		PDM_FN_PT0_OUT = 5'h01,
		PDM_FN_PT0_OUTN = 5'h02,
		PDM_FN_PT1_OUT = 5'h03,
		PDM_FN_PT2_OUT = 5'h04,
		PDM_FN_ST_OUT = 5'h05,
		PDM_FN_ST_OUTN = 5'h06,
		PDM_FN_SPIA_SDO = 5'h07,
		PDM_FN_SPIA_SCK = 5'h08,
		PDM_FN_SPIA_SCS = 5'h09,
		PDM_FN_SPIA_SDI = 5'h0a,
		PDM_FN_UART_TX = 5'h0b,
		PDM_FN_UART_RXTX = 5'h0c,
		PDM_FN_SIM_SDO = 5'h0d,
		PDM_FN_SIM_SCS = 5'h0e,
		PDM_FN_SIM_SDA = 5'h0f,
		PDM_FN_ANALOG = 5'h10
	} pdm_func_t;
	typedef logic [1:0] pdm_level_t;
endpackage

// file: include/pdm_pad_if.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Configuration in, pad drive out, for one pin
// ----------------------------------------
interface pdm_pad_if;
	import pdm_pkg::*;
	logic dir; // 1 input, 0 output
	logic latch; // Output data latch
	pdm_level_t level; // Selected drive level
	pdm_func_t func; // Routed function
	logic per_out; // Peripheral output for this function
	logic per_oe_n; // Peripheral enable, low drives
	logic pin_out; // Level to the pad
	logic pin_oe_n; // Pad enable, low drives
	logic ana_en; // Pad handed to analogue use
	pdm_level_t drv; // Drive level reaching the pad
	modport cfg (output dir, latch, level, func, per_out, per_oe_n, input pin_out, pin_oe_n, ana_en, drv);
	modport pad (input dir, latch, level, func, per_out, per_oe_n, output pin_out, pin_oe_n, ana_en, drv);
endinterface
`default_nettype wire

// file: logic/pdm_pad.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Pad multiplexer for one pin
// ----------------------------------------
module pdm_pad (
	pdm_pad_if.pad p
);
	import pdm_pkg::*;

	// Choose source and enable from routed function
	always_comb begin
		p.pin_out = 1'b0;
		p.pin_oe_n = 1'b1;
		p.ana_en = 1'b0;
		case (p.func)
			PDM_FN_GPIO: begin
				p.pin_out = p.latch;
				p.pin_oe_n = p.dir;
			end
			PDM_FN_ANALOG: begin
				p.ana_en = 1'b1; // Driver off, pad to analogue
			end
			PDM_FN_SPIA_SDI: begin
				p.pin_oe_n = 1'b1; // Input only
			end
			default: begin
				p.pin_out = p.per_out; // Peripheral owns the pad
				p.pin_oe_n = p.per_oe_n;
			end
		endcase
	end

	// Level reaches the pad only while it is a CMOS output
	always_comb begin
		p.drv = p.pin_oe_n ? 2'h0 : p.level;
	end
endmodule
`default_nettype wire

// file: logic/pdm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdm_map.svh"
module pdm_top (
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	input wire logic I_CE,
	input wire logic [4:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	input wire logic [`PDM_NPIN-1:0] I_PIN_IN,
	output logic [`PDM_NPIN-1:0] O_PIN_OUT,
	output logic [`PDM_NPIN-1:0] O_PIN_OE_N,
	output logic [`PDM_NPIN-1:0] O_ANALOG_EN,
	output logic [2*`PDM_NPIN-1:0] O_DRIVE,
	output logic [`PDM_NPIN-1:0] O_PIN_LEVEL,
	input wire logic [`PDM_NFUNC-1:0] I_PERIPH_OUT,
	input wire logic [`PDM_NFUNC-1:0] I_PERIPH_OE_N,
	output logic [`PDM_NFUNC-1:0] O_PERIPH_IN
);
	import pdm_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] data_q [5]; // Output data latches A..E
	logic [7:0] dir_q [5]; // Direction A..E
	logic [7:0] lvl_ab_q; // Drive levels ports A, B
	logic [7:0] lvl_cd_q; // Drive levels ports C, D
	logic [1:0] lvl_e_q; // Drive level port E
	logic [7:0] fn_a_lo_q; // Port A pins 3..0 selectors
	logic [7:0] fn_a_hi_q; // Port A pins 7..4 selectors
	logic [7:0] fn_b_lo_q; // Port B pins 3..0 selectors
	logic [7:0] rdata_d; // Read data before the flop
	logic [`PDM_NPIN-1:0] dir_flat; // Direction per pin
	logic [`PDM_NPIN-1:0] latch_flat; // Latch per pin
	logic [`PDM_NPIN-1:0] pad_out; // Pad values before the flops
	logic [`PDM_NPIN-1:0] pad_oe_n;
	logic [`PDM_NPIN-1:0] pad_ana;
	logic [2*`PDM_NPIN-1:0] pad_drv;
	pdm_func_t pin_fn [`PDM_NPIN]; // Routed function per pin
	logic [`PDM_NFUNC-1:0] per_in_d; // Pin levels routed to peripherals

	// ----------------------------------------
	// Function routing tables
	// ----------------------------------------
	// Map one pin's selector code to its function
	function automatic pdm_func_t route(input int pin, input logic [1:0] s);
		pdm_func_t f;
		f = PDM_FN_GPIO;
		case (pin)
			0: f = (s == 2'h2) ? PDM_FN_PT0_OUT : (s == 2'h3) ? PDM_FN_ANALOG : PDM_FN_GPIO;
			1: f = (s == 2'h2) ? PDM_FN_ANALOG : (s == 2'h3) ? PDM_FN_PT0_OUTN : PDM_FN_GPIO;
			2: f = (s == 2'h3) ? PDM_FN_ANALOG : PDM_FN_GPIO;
			3: begin
				case (s)
					2'h1: f = PDM_FN_PT1_OUT;
					2'h2: f = PDM_FN_SPIA_SDO;
					2'h3: f = PDM_FN_ANALOG;
					default: f = PDM_FN_GPIO;
				endcase
			end
			4: begin
				case (s)
					2'h1: f = PDM_FN_PT2_OUT;
					2'h2: f = PDM_FN_SPIA_SCS;
					2'h3: f = PDM_FN_ANALOG;
					default: f = PDM_FN_GPIO;
				endcase
			end
			5: begin
				case (s)
					2'h1: f = PDM_FN_ST_OUT;
					2'h2: f = PDM_FN_SPIA_SCK;
					2'h3: f = PDM_FN_UART_TX;
					default: f = PDM_FN_GPIO;
				endcase
			end
			6: f = (s == 2'h1) ? PDM_FN_SPIA_SDI : (s == 2'h3) ? PDM_FN_UART_RXTX : PDM_FN_GPIO;
			7: f = (s == 2'h3) ? PDM_FN_SIM_SDA : PDM_FN_GPIO;
			9: begin
				case (s)
					2'h1: f = PDM_FN_ANALOG;
					2'h2: f = PDM_FN_ANALOG;
					2'h3: f = PDM_FN_ST_OUTN;
					default: f = PDM_FN_GPIO;
				endcase
			end
			10: f = (s == 2'h2) ? PDM_FN_SIM_SCS : (s == 2'h3) ? PDM_FN_SPIA_SCK : PDM_FN_GPIO;
			11: begin
				case (s)
					2'h1: f = PDM_FN_UART_RXTX;
					2'h2: f = PDM_FN_SPIA_SDI;
					2'h3: f = PDM_FN_SIM_SDO;
					default: f = PDM_FN_GPIO;
				endcase
			end
			default: f = PDM_FN_GPIO; // Remaining pins stay general I/O
		endcase
		return f;
	endfunction

	// Drive level field serving one pin
	function automatic pdm_level_t level_of(input int pin, input logic [7:0] ab, input logic [7:0] cd,
		input logic [1:0] e);
		pdm_level_t l;
		case (pin / 4)
			0: l = ab[1:0];
			1: l = ab[3:2];
			2: l = ab[5:4];
			3: l = ab[7:6];
			4: l = cd[1:0];
			5: l = cd[3:2];
			6: l = cd[5:4];
			7: l = cd[7:6];
			default: l = e;
		endcase
		return l;
	endfunction

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Data latches and direction, one word per port
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			for (int k = 0; k < 5; k++) begin
				data_q[k] <= `PDM_RST_DATA;
				dir_q[k] <= `PDM_RST_DIR;
			end
		end else if (I_CE && I_WR) begin
			for (int k = 0; k < 5; k++) begin
				if (I_ADDR == `PDM_OFS_DATA_A + 5'(k)) begin
					data_q[k] <= (k == 4) ? (I_WDATA & `PDM_PE_MASK) : I_WDATA;
				end
				if (I_ADDR == `PDM_OFS_DIR_A + 5'(k)) begin
					dir_q[k] <= (k == 4) ? (I_WDATA | ~`PDM_PE_MASK) : I_WDATA;
				end
			end
		end
	end

	// Drive levels and function selectors
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			lvl_ab_q <= `PDM_RST_LVL;
			lvl_cd_q <= `PDM_RST_LVL;
			lvl_e_q <= 2'h0;
			fn_a_lo_q <= `PDM_RST_FN;
			fn_a_hi_q <= `PDM_RST_FN;
			fn_b_lo_q <= `PDM_RST_FN;
		end else if (I_CE && I_WR) begin
			case (I_ADDR)
				`PDM_OFS_LVL_AB: lvl_ab_q <= I_WDATA;
				`PDM_OFS_LVL_CD: lvl_cd_q <= I_WDATA;
				`PDM_OFS_LVL_E: lvl_e_q <= I_WDATA[1:0];
				`PDM_OFS_FN_A_LO: fn_a_lo_q <= I_WDATA;
				`PDM_OFS_FN_A_HI: fn_a_hi_q <= I_WDATA;
				`PDM_OFS_FN_B_LO: fn_b_lo_q <= I_WDATA;
				default: begin
					// Unmapped writes are ignored
				end
			endcase
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// Flatten per-port state onto the pin vectors
	always_comb begin
		for (int k = 0; k < `PDM_NPIN; k++) begin
			dir_flat[k] = dir_q[k / 8][k % 8];
			latch_flat[k] = data_q[k / 8][k % 8];
		end
	end

	// Read mux; data words mix pin and latch per direction bit
	always_comb begin
		logic [7:0] pins;
		pins = 8'h00;
		rdata_d = 8'h00;
		for (int k = 0; k < 5; k++) begin
			pins = 8'h00;
			for (int b = 0; b < 8; b++) begin
				if (k * 8 + b < `PDM_NPIN) begin
					pins[b] = I_PIN_IN[k * 8 + b];
				end
			end
			if (I_ADDR == `PDM_OFS_DATA_A + 5'(k)) begin
				rdata_d = (dir_q[k] & pins) | (~dir_q[k] & data_q[k]);
				if (k == 4) begin
					rdata_d = rdata_d & `PDM_PE_MASK;
				end
			end
			if (I_ADDR == `PDM_OFS_DIR_A + 5'(k)) begin
				rdata_d = (k == 4) ? (dir_q[k] & `PDM_PE_MASK) : dir_q[k];
			end
		end
		case (I_ADDR)
			`PDM_OFS_LVL_AB: rdata_d = lvl_ab_q;
			`PDM_OFS_LVL_CD: rdata_d = lvl_cd_q;
			`PDM_OFS_LVL_E: rdata_d = {6'h00, lvl_e_q};
			`PDM_OFS_FN_A_LO: rdata_d = fn_a_lo_q;
			`PDM_OFS_FN_A_HI: rdata_d = fn_a_hi_q;
			`PDM_OFS_FN_B_LO: rdata_d = fn_b_lo_q;
			default: begin
				// Keep port words or zero
			end
		endcase
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			O_RDATA <= 8'h00;
		end else if (I_CE) begin
			O_RDATA <= I_RD ? rdata_d : 8'h00;
		end
	end

	// ----------------------------------------
	// Pads
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `PDM_NPIN; g++) begin : pin
			pdm_pad_if pif ();
			logic [1:0] sel;
			// Selector field of this pin
			assign sel = (g < 4) ? fn_a_lo_q[2*(g%4)+:2] : (g < 8) ? fn_a_hi_q[2*(g%4)+:2] :
				(g < 12) ? fn_b_lo_q[2*(g%4)+:2] : 2'h0;
			assign pin_fn[g] = route(g, sel);
			assign pif.dir = dir_flat[g];
			assign pif.latch = latch_flat[g];
			assign pif.level = level_of(g, lvl_ab_q, lvl_cd_q, lvl_e_q);
			assign pif.func = pin_fn[g];
			assign pif.per_out = I_PERIPH_OUT[pin_fn[g]];
			assign pif.per_oe_n = I_PERIPH_OE_N[pin_fn[g]];
			assign pad_out[g] = pif.pin_out;
			assign pad_oe_n[g] = pif.pin_oe_n;
			assign pad_ana[g] = pif.ana_en;
			assign pad_drv[2*g+:2] = pif.drv;
			pdm_pad u_pad (
				.p(pif.pad)
			);
		end
	endgenerate

	// Route pin levels to peripheral inputs on functions other than GPIO and analogue
	always_comb begin
		per_in_d = '0;
		for (int k = 0; k < `PDM_NPIN; k++) begin
			if (pin_fn[k] != PDM_FN_GPIO && pin_fn[k] != PDM_FN_ANALOG) begin
				per_in_d[pin_fn[k]] = per_in_d[pin_fn[k]] | I_PIN_IN[k];
			end
		end
	end

	// Registered pad and peripheral outputs
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			O_PIN_OUT <= '0;
			O_PIN_OE_N <= '1;
			O_ANALOG_EN <= '0;
			O_DRIVE <= '0;
			O_PIN_LEVEL <= '0;
			O_PERIPH_IN <= '0;
		end else if (I_CE) begin
			O_PIN_OUT <= pad_out;
			O_PIN_OE_N <= pad_oe_n;
			O_ANALOG_EN <= pad_ana;
			O_DRIVE <= pad_drv;
			O_PIN_LEVEL <= I_PIN_IN; // Shared digital inputs, direction set by software
			O_PERIPH_IN <= per_in_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	dir_write_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(I_CE && I_WR && I_ADDR == `PDM_OFS_DIR_A) |=> dir_q[0] == $past(I_WDATA))
		else $error("direction write not stored");
	read_input_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(I_CE && I_RD && I_ADDR == `PDM_OFS_DATA_A && dir_q[0] == 8'hff) |=> O_RDATA == $past(I_PIN_IN[7:0]))
		else $error("input read does not show pin");
	read_latch_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(I_CE && I_RD && I_ADDR == `PDM_OFS_DATA_A && dir_q[0] == 8'h00) |=> O_RDATA == $past(data_q[0]))
		else $error("output read does not show latch");
	drive_gate_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		O_PIN_OE_N[0] |-> O_DRIVE[1:0] == 2'h0)
		else $error("drive level on a pin not driving");
	level_e_read_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(I_CE && I_RD && I_ADDR == `PDM_OFS_LVL_E) |=> O_RDATA[7:2] == 6'h00)
		else $error("unimplemented level bits not zero");
	pa0_timer_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(I_CE && fn_a_lo_q[1:0] == 2'h2) |=> O_PIN_OUT[0] == $past(I_PERIPH_OUT[PDM_FN_PT0_OUT]))
		else $error("PA0 timer output not routed");
	pb1_analog_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(I_CE && fn_b_lo_q[3:2] == 2'h1) |=> (O_ANALOG_EN[9] && O_PIN_OE_N[9]))
		else $error("PB1 analogue not selected");
	route_lag_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(I_CE && I_WR && I_ADDR == `PDM_OFS_FN_A_LO && I_WDATA[1:0] == 2'h3) ##1 I_CE |=> O_ANALOG_EN[0])
		else $error("selector write not applied");
	pa5_tx_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(I_CE && fn_a_hi_q[3:2] == 2'h3) |=> O_PIN_OUT[5] == $past(I_PERIPH_OUT[PDM_FN_UART_TX]))
		else $error("PA5 transmit not routed");
	ce_hold_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		!I_CE |=> ($stable(O_RDATA) && $stable(O_PIN_OE_N) && $stable(dir_q[0])))
		else $error("clock enable low did not freeze state");
	reset_out_a: assert property (@(posedge I_CLOCK)
		I_RESET |=> (O_PIN_OE_N == '1 && O_RDATA == 8'h00 && dir_q[0] == `PDM_RST_DIR))
		else $error("reset left a pin driving");
	drive_level_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(I_CE && !pad_oe_n[0]) |=> O_DRIVE[1:0] == $past(lvl_ab_q[1:0]))
		else $error("driving pin lacks its level");
	pb2_select_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		(I_CE && fn_b_lo_q[5:4] == 2'h2) |=> O_PIN_OE_N[10] == $past(I_PERIPH_OE_N[PDM_FN_SIM_SCS]))
		else $error("PB2 serial select not routed");
	out_cover: cover property (@(posedge I_CLOCK) disable iff (I_RESET) I_CE && !O_PIN_OE_N[0] && O_DRIVE[1:0] == 2'h3);
	read_cover: cover property (@(posedge I_CLOCK) disable iff (I_RESET) I_CE && I_RD && I_ADDR == `PDM_OFS_DATA_A);
	analog_cover: cover property (@(posedge I_CLOCK) disable iff (I_RESET) O_ANALOG_EN[2]);
endmodule
`default_nettype wire

// file: verification/pdm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External circuitry seen by the pads
// ----------------------------------------
module pdm_pin_model (
	input wire logic i_clk,
	input wire logic [34:0] i_pin_out,
	input wire logic [34:0] i_pin_oe_n,
	input wire logic [34:0] i_ext_en,
	input wire logic [34:0] i_ext_val,
	output logic [34:0] o_pin_in
);
	logic [34:0] last_q; // Wire level at the previous edge
	// Keep the last level so a floating pad can wander away from it
	always_ff @(posedge i_clk) begin
		last_q <= o_pin_in;
	end
	// A strong load wins, then the pad driver, else the pad floats
	always_comb begin
		for (int p = 0; p < 35; p++) begin
			if (i_ext_en[p]) begin
				o_pin_in[p] = i_ext_val[p];
			end else if (!i_pin_oe_n[p]) begin
				o_pin_in[p] = i_pin_out[p];
			end else begin
				o_pin_in[p] = ~last_q[p];
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/port_direction_drive_and_pin_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdm_map.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module port_direction_drive_and_pin_mux_tb;
	import pdm_pkg::*;
	// ----------------------------------------
	// Signals and bench state
	// ----------------------------------------
	logic I_CLOCK, I_RESET, I_CE, I_WR, I_RD;
	logic [4:0] I_ADDR;
	logic [7:0] I_WDATA, O_RDATA;
	logic [34:0] I_PIN_IN, O_PIN_OUT, O_PIN_OE_N, O_ANALOG_EN, O_PIN_LEVEL, ext_en, ext_val;
	logic [69:0] O_DRIVE;
	logic [16:0] I_PERIPH_OUT, I_PERIPH_OE_N, O_PERIPH_IN;
	logic [39:0] pinx; // Pads padded to five bytes
	logic [39:0] tmp; // Random scratch
	logic [15:0] seed_q; // Random state
	logic [7:0] dir_m[5], lat_m[5], lvl_m[3], sel_m[3]; // Expected register contents
	int fail_count, total_checks;
	// Function per pin and selector code, values of the package enum
	localparam logic [4:0] FT [12][4] = '{'{5'h00, 5'h00, 5'h01, 5'h10}, '{5'h00, 5'h00, 5'h10, 5'h02},
		'{5'h00, 5'h00, 5'h00, 5'h10}, '{5'h00, 5'h03, 5'h07, 5'h10}, '{5'h00, 5'h04, 5'h09, 5'h10},
		'{5'h00, 5'h05, 5'h08, 5'h0b}, '{5'h00, 5'h0a, 5'h00, 5'h0c}, '{5'h00, 5'h00, 5'h00, 5'h0f},
		'{5'h00, 5'h00, 5'h00, 5'h00}, '{5'h00, 5'h10, 5'h10, 5'h06}, '{5'h00, 5'h00, 5'h0e, 5'h08},
		'{5'h00, 5'h0c, 5'h0a, 5'h0d}};
	assign pinx = {5'h00, I_PIN_IN};
	pdm_top dut (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_CE(I_CE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
		.I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PIN_IN(I_PIN_IN), .O_PIN_OUT(O_PIN_OUT),
		.O_PIN_OE_N(O_PIN_OE_N), .O_ANALOG_EN(O_ANALOG_EN), .O_DRIVE(O_DRIVE), .O_PIN_LEVEL(O_PIN_LEVEL),
		.I_PERIPH_OUT(I_PERIPH_OUT), .I_PERIPH_OE_N(I_PERIPH_OE_N), .O_PERIPH_IN(O_PERIPH_IN));
	pdm_pin_model partner (.i_clk(I_CLOCK), .i_pin_out(O_PIN_OUT), .i_pin_oe_n(O_PIN_OE_N),
		.i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin_in(I_PIN_IN));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Eight shift steps of the random source per byte
	function automatic logic [7:0] rnd8();
		for (int s = 0; s < 8; s++) begin
			seed_q = {seed_q[14:0], seed_q[15] ^ seed_q[13] ^ seed_q[12] ^ seed_q[10]};
		end
		return seed_q[7:0];
	endfunction
	task automatic rnd40();
		for (int k = 0; k < 5; k++) begin
			tmp[8*k+:8] = rnd8();
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge I_CLOCK);
		I_WR <= 1'b1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_CLOCK);
		I_WR <= 1'b0;
	endtask
	// One-cycle read strobe, data looked at in the following cycle only
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
		@(posedge I_CLOCK);
		I_RD <= 1'b1;
		I_ADDR <= a;
		@(posedge I_CLOCK);
		I_RD <= 1'b0;
		#1;
		`CHK(O_RDATA, e)
	endtask
	// Input pins read the pad, output pins read the latch
	function automatic logic [7:0] exp_data(input int k);
		return ((dir_m[k] & pinx[8*k+:8]) | (~dir_m[k] & lat_m[k])) & ((k == 4) ? 8'h07 : 8'hff);
	endfunction
	task automatic chk_regs();
		for (int k = 0; k < 5; k++) begin
			rd_chk(`PDM_OFS_DATA_A + 5'(k), exp_data(k));
			rd_chk(`PDM_OFS_DIR_A + 5'(k), dir_m[k]);
		end
		for (int k = 0; k < 3; k++) begin
			rd_chk(`PDM_OFS_LVL_AB + 5'(k), lvl_m[k]);
			rd_chk(`PDM_OFS_FN_A_LO + 5'(k), sel_m[k]);
		end
		rd_chk(5'h1f, 8'h00);
	endtask
	// Pad outputs against the expected routing of every pin
	task automatic chk_pins();
		logic [4:0] f;
		logic d;
		logic sdi;
		logic [1:0] lv;
		logic [16:0] pin_or;
		sdi = 1'b0;
		pin_or = '0;
		for (int p = 0; p < 35; p++) begin
			f = (p < 12) ? FT[p][sel_m[p/4][2*(p%4)+:2]] : 5'h00;
			d = dir_m[p/8][p%8];
			lv = lvl_m[p/16][2*((p/4)%4)+:2];
			// Pin level expected on the peripheral input of its function
			if (f != 5'h00 && f != 5'h10) pin_or[f] = pin_or[f] | I_PIN_IN[p];
			if (f == 5'h00) begin
				`CHK(O_PIN_OE_N[p], d)
				`CHK(O_ANALOG_EN[p], 1'b0)
				`CHK(O_DRIVE[2*p+:2], d ? 2'b00 : lv)
				if (!d) `CHK(O_PIN_OUT[p], lat_m[p/8][p%8])
			end else if (f == 5'h10) begin
				`CHK(O_ANALOG_EN[p], 1'b1)
			end else if (f == 5'h0a) begin
				`CHK(O_PIN_OE_N[p], 1'b1)
				sdi = sdi | I_PIN_IN[p];
			end else begin
				`CHK(O_PIN_OE_N[p], I_PERIPH_OE_N[f])
				if (!I_PERIPH_OE_N[f]) `CHK(O_PIN_OUT[p], I_PERIPH_OUT[f])
			end
		end
		`CHK(O_PERIPH_IN[5'h0a], sdi)
		`CHK(O_PERIPH_IN, pin_or)
		`CHK(O_PIN_LEVEL, I_PIN_IN)
	endtask
	task automatic end_sim();
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		I_CLOCK = 1'b0;
		forever #5 I_CLOCK = ~I_CLOCK;
	end
	initial begin
		#300000;
		fail_count++;
		end_sim();
	end
	initial begin
		I_RESET = 1'b1;
		I_CE = 1'b1;
		{I_WR, I_RD, I_ADDR, I_WDATA} = '0;
		{ext_en, I_PERIPH_OE_N} = '1;
		{ext_val, I_PERIPH_OUT} = '0;
		seed_q = 16'h7af6;
		fail_count = 0;
		total_checks = 0;
		dir_m = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h07};
		lat_m = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h07};
		lvl_m = '{8'h00, 8'h00, 8'h00};
		sel_m = '{8'h00, 8'h00, 8'h00};
		repeat (2) @(posedge I_CLOCK);
		I_RESET <= 1'b0;
		#1;
		`CHK(O_PIN_OE_N, {35{1'b1}})
		`CHK(O_DRIVE, 70'h0)
		chk_regs();
		// Pin 0 turns to output one edge after the register takes the write
		wr(`PDM_OFS_DIR_A, 8'hfe);
		dir_m[0] = 8'hfe;
		#1;
		`CHK(O_PIN_OE_N[0], 1'b1)
		@(posedge I_CLOCK);
		#1;
		`CHK(O_PIN_OE_N[0], 1'b0)
		`CHK(O_PIN_OUT[0], 1'b1)
		// General I/O: first all outputs at full drive, then all inputs, then random
		for (int i = 0; i < 24; i++) begin
			for (int k = 0; k < 5; k++) begin
				tmp[7:0] = rnd8();
				tmp[15:8] = rnd8();
				if (i < 2) tmp[15:0] = (i == 0) ? 16'h00a5 : 16'hff00;
				wr(`PDM_OFS_DATA_A + 5'(k), tmp[7:0]);
				wr(`PDM_OFS_DIR_A + 5'(k), tmp[15:8]);
				lat_m[k] = (k == 4) ? (tmp[7:0] & `PDM_PE_MASK) : tmp[7:0];
				dir_m[k] = (k == 4) ? (tmp[15:8] & `PDM_PE_MASK) : tmp[15:8];
			end
			for (int k = 0; k < 3; k++) begin
				tmp[7:0] = rnd8();
				if (i == 0) tmp[7:0] = 8'hff;
				wr(`PDM_OFS_LVL_AB + 5'(k), tmp[7:0]);
				lvl_m[k] = (k == 2) ? (tmp[7:0] & `PDM_LVL_E_MASK) : tmp[7:0];
			end
			rnd40();
			@(posedge I_CLOCK);
			ext_val <= tmp[34:0];
			rnd40();
			ext_en <= tmp[34:0] | {dir_m[4][2:0], dir_m[3], dir_m[2], dir_m[1], dir_m[0]};
			repeat (3) @(posedge I_CLOCK);
			#1;
			chk_pins();
			chk_regs();
		end
		// Shared functions: every code on every field, then random mixes
		for (int i = 0; i < 12; i++) begin
			@(posedge I_CLOCK);
			I_PERIPH_OE_N <= '1;
			for (int k = 0; k < 3; k++) begin
				tmp[7:0] = rnd8();
				if (i < 4) tmp[7:0] = {4{2'(i)}};
				wr(`PDM_OFS_FN_A_LO + 5'(k), tmp[7:0]);
				sel_m[k] = tmp[7:0];
			end
			for (int k = 0; k < 2; k++) begin
				wr(`PDM_OFS_DIR_A + 5'(k), 8'hff);
				dir_m[k] = 8'hff;
			end
			rnd40();
			@(posedge I_CLOCK);
			ext_en <= '1;
			ext_val <= tmp[34:0];
			I_PERIPH_OUT <= tmp[39:23];
			rnd40();
			I_PERIPH_OE_N <= tmp[16:0];
			repeat (3) @(posedge I_CLOCK);
			#1;
			chk_pins();
			chk_regs();
		end
		// Clock enable low: the write below is ignored and state holds
		@(posedge I_CLOCK);
		I_CE <= 1'b0;
		wr(`PDM_OFS_DIR_A, ~dir_m[0]);
		@(posedge I_CLOCK);
		I_CE <= 1'b1;
		rd_chk(`PDM_OFS_DIR_A, dir_m[0]);
		// Read data fall back to zero in the cycle after
		@(posedge I_CLOCK);
		#1;
		`CHK(O_RDATA, 8'h00)
		// Reset in mid-run restores every register and pad default
		@(posedge I_CLOCK);
		I_RESET <= 1'b1;
		repeat (2) @(posedge I_CLOCK);
		I_RESET <= 1'b0;
		dir_m = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h07};
		lat_m = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h07};
		lvl_m = '{8'h00, 8'h00, 8'h00};
		sel_m = '{8'h00, 8'h00, 8'h00};
		#1;
		`CHK(O_PIN_OE_N, {35{1'b1}})
		`CHK(O_PIN_OUT, 35'h0)
		`CHK(O_DRIVE, 70'h0)
		repeat (2) @(posedge I_CLOCK);
		#1;
		chk_pins();
		chk_regs();
		end_sim();
	end
endmodule
`default_nettype wire
